/* logic/cmd_decode_pkg.sv */
/*
 Shared constants for the command-interface decoder of a low-power DDR
 memory device: command codes, bus and field widths and timing counts.
 Assumes a single 125 MHz system clock for all users.
*/
package cmd_decode_pkg;
  // System clock period in picoseconds (125 MHz)
  localparam int CLK_PERIOD_PS = 8000;
  // Clock-qualification cycles before leaving a stop or exit
  localparam int CLK_QUAL_CYCLES = 2;
  // Power-down exit latency in ns, plain default
  localparam int EXIT_LAT_NS = 8;
  // Exit latency in cycles, rounded up, at least one
  localparam int EXIT_LAT_CYCLES =
    ((EXIT_LAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((EXIT_LAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Ready wait after clock stop or frequency change
  localparam int READY_WAIT_CYCLES = CLK_QUAL_CYCLES + EXIT_LAT_CYCLES;
  localparam int WAIT_W = 4;

  // Command bus and field widths
  localparam int CA_W = 10;
  localparam int MA_W = 8;
  localparam int OP_W = 8;
  localparam int ROW_W = 13;
  localparam int BANK_W = 3;

  // Decoded command kinds
  typedef enum logic [2:0] {
    CMD_NOP  = 3'h0,
    CMD_MRW  = 3'h1,
    CMD_MRR  = 3'h2,
    CMD_ACT  = 3'h3,
    CMD_DPD  = 3'h4,
    CMD_OTHR = 3'h5,
    CMD_PDN  = 3'h6
  } cmd_kind_e;

  // Device power states seen by the decoder
  typedef enum logic [1:0] {
    ST_NORMAL = 2'h0,
    ST_DEEP_PD = 2'h1,
    ST_WAIT_READY = 2'h2,
    ST_NEED_INIT = 2'h3
  } dev_state_e;
endpackage

/* logic/ready_wait_counter.sv */
/*
 Down-counter that measures the clock-qualification period plus exit
 latency before the command decoder may accept normal commands.
 Assumes the caller pulses start for one cycle on a wait request.
*/
`timescale 1ns/10ps
module ready_wait_counter
  import cmd_decode_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic clk_ok_in,
  output logic done_out
);
  logic [WAIT_W-1:0] count_ff;
  logic [WAIT_W-1:0] nxt_count;
  logic busy_ff;
  logic nxt_busy;
  logic finish;

  // Only clean clock cycles count; a bad cycle restarts the wait
  assign finish = busy_ff && clk_ok_in && (count_ff == WAIT_W'(1));
  assign nxt_count = start_in ? WAIT_W'(READY_WAIT_CYCLES) :
    (!clk_ok_in ? WAIT_W'(READY_WAIT_CYCLES) :
    (busy_ff ? count_ff - WAIT_W'(1) : count_ff)); // [R10] [R12]
  assign nxt_busy = start_in || (busy_ff && !finish);
  assign done_out = finish;

  // Counter registers
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      count_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      busy_ff <= nxt_busy;
    end
  end
endmodule

/* logic/cmd_decode.sv */
/*
 Command decoder of a low-power DDR device. Samples chip select and clock
 enable on the rising edge and the ten-bit command/address bus on both clock edges (the
 falling-edge half is presented by the pad logic as ca_fall_in) and
 reports decoded commands, fields and readiness.
 Assumes pins arrive from outside the clock domain and are synchronised
 here; clk_ok_in flags that the current period met its high/low limits.
*/
`timescale 1ns/10ps
// Functional notes
// R1: Controller may start initialization any time after the post-exit point.
// R2: Clock may stop in deep power-down; two stable cycles needed before exit.
// R3: During frequency change only refresh operations may be executing.
// R4: Activates and precharges complete before a clock-enable-low change.
// R5: Original clock frequency kept two cycles after clock enable falls.
// R6: Two in-limit clock cycles precede clock enable rising again.
// R7: Stopped clock parks true low, complement high; only refresh runs.
// R8: All accesses and recoveries finish before a clock-enable-high change.
// R9: Chip select stays high throughout a clock-enable-high frequency change.
// R10: After such a change, ready after two good periods plus exit latency.
// R11: Chip select stays high for the whole clock-enable-high clock stop.
// R12: After a restarted clock, ready after two good periods plus latency.
// R13: Mode register writes may be needed after a rate change.
// R14: No-operation only when clock enable is equal in cycles N-1 and N.
// R15: No-operation is chip select high, or low with bits 0-2 high.
// R16: No-operation never aborts an operation in progress.
// R17: Unspecified operation is illegal; recovery needs re-initialization.
// R18: Mode register write/read decode with address and data fields.
// R19: Activate decode with row and bank fields from both edges.
// R20: Commands come from chip select, bits 0-3 and clock enable.
// R21: Deep power-down exit needs enable and select high, then re-init.
module cmd_decode
  import cmd_decode_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic cke_in,
  input wire logic cs_b_in,
  input wire logic [CA_W-1:0] ca_rise_in,
  input wire logic [CA_W-1:0] ca_fall_in,
  input wire logic clk_ok_in,
  input wire logic init_done_in,
  input wire logic op_busy_in,
  output logic cmd_valid_out,
  output cmd_kind_e cmd_kind_out,
  output logic [MA_W-1:0] mr_addr_out,
  output logic [OP_W-1:0] mr_data_out,
  output logic [ROW_W-1:0] row_out,
  output logic [BANK_W-1:0] bank_out,
  output logic ready_out,
  output logic need_init_out,
  output logic illegal_out,
  output logic op_hold_out
);
  // Two-stage synchronisers for all pin inputs
  logic cke_s1_ff, cke_s2_ff, cs_s1_ff, cs_s2_ff, ok_s1_ff, ok_s2_ff;
  logic [CA_W-1:0] car_s1_ff, car_s2_ff, caf_s1_ff, caf_s2_ff;
  logic cke_prev_ff;
  logic clk_ok_cnt_ok_ff;
  logic [1:0] good_cnt_ff;
  logic [1:0] nxt_good_cnt;
  dev_state_e state_ff, nxt_state;
  logic cmd_valid_ff;
  cmd_kind_e kind_ff;
  logic [MA_W-1:0] ma_ff;
  logic [OP_W-1:0] op_ff;
  logic [ROW_W-1:0] row_ff;
  logic [BANK_W-1:0] bank_ff;
  logic illegal_ff, nxt_illegal;
  logic wait_start, wait_done;

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      // Enable rests at its idle high level, so no false rise after reset
      cke_s1_ff <= 1'b1;
      cke_s2_ff <= 1'b1;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      ok_s1_ff <= 1'b0;
      ok_s2_ff <= 1'b0;
      car_s1_ff <= '0;
      car_s2_ff <= '0;
      caf_s1_ff <= '0;
      caf_s2_ff <= '0;
    end else begin
      cke_s1_ff <= cke_in;
      cke_s2_ff <= cke_s1_ff;
      cs_s1_ff <= cs_b_in;
      cs_s2_ff <= cs_s1_ff;
      ok_s1_ff <= clk_ok_in;
      ok_s2_ff <= ok_s1_ff;
      car_s1_ff <= ca_rise_in;
      car_s2_ff <= car_s1_ff;
      caf_s1_ff <= ca_fall_in;
      caf_s2_ff <= caf_s1_ff;
    end
  end

  // Command classification from select, bits 0-3 and enable [R20]
  logic cke_both, cke_fall, cke_rise;
  logic is_nop, is_mrw, is_mrr, is_act, is_dpd, is_pdn;
  assign cke_both = cke_prev_ff && cke_s2_ff;
  assign cke_fall = cke_prev_ff && !cke_s2_ff;
  assign cke_rise = !cke_prev_ff && cke_s2_ff;
  // Either encoding counts, never while enable is changing [R15] [R14]
  assign is_nop = cke_both && (cs_s2_ff ||
    (car_s2_ff[2:0] == 3'h7));
  assign is_mrw = cke_both && !cs_s2_ff &&
    (car_s2_ff[3:0] == 4'h0); // [R18]
  assign is_mrr = cke_both && !cs_s2_ff &&
    (car_s2_ff[3:0] == 4'h8); // [R18]
  assign is_act = cke_both && !cs_s2_ff &&
    (car_s2_ff[1:0] == 2'h2); // [R19]
  assign is_dpd = cke_fall && !cs_s2_ff &&
    (car_s2_ff[2:0] == 3'h3);
  assign is_pdn = cke_fall && cs_s2_ff;

  // Two good clock periods are needed before enable may rise [R2] [R6]
  assign nxt_good_cnt = !ok_s2_ff ? 2'h0 :
    (good_cnt_ff == 2'(CLK_QUAL_CYCLES) ? good_cnt_ff :
    good_cnt_ff + 2'h1);

  // Enable rising without qualified clock, or a clock-enable-high
  // stop with select low, is an unspecified operation [R17] [R11] [R9]
  logic bad_exit, bad_stop_cs, bad_busy_stop;
  assign bad_exit = cke_rise &&
    (good_cnt_ff != 2'(CLK_QUAL_CYCLES)); // [R6]
  assign bad_stop_cs = cke_s2_ff && !ok_s2_ff && !cs_s2_ff;
  assign bad_busy_stop = !ok_s2_ff && op_busy_in; // [R8] [R3] [R4]

  // Power state sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_illegal = illegal_ff;
    wait_start = 1'b0;
    unique case (state_ff)
      ST_NORMAL: begin
        if (is_dpd) begin
          nxt_state = ST_DEEP_PD;
        end else if (cke_s2_ff && !ok_s2_ff) begin
          nxt_state = ST_WAIT_READY; // [R10] [R12]
        end
      end
      ST_DEEP_PD: begin
        // Exit needs enable and select high with a good clock [R21]
        if (cke_rise && cs_s2_ff && !bad_exit) begin
          nxt_state = ST_NEED_INIT;
        end
      end
      ST_WAIT_READY: begin
        if (ok_s2_ff && good_cnt_ff == 2'h0) begin
          wait_start = 1'b1;
        end
        if (wait_done) begin
          nxt_state = ST_NORMAL;
        end
      end
      ST_NEED_INIT: begin
        // Re-initialization clears the illegal condition [R1] [R17]
        if (init_done_in) begin
          nxt_state = ST_NORMAL;
          nxt_illegal = 1'b0;
        end
      end
    endcase
    // An illegal event forces re-initialization before any command [R17]
    if (illegal_ff && (state_ff inside {ST_NORMAL, ST_WAIT_READY})) begin
      nxt_state = ST_NEED_INIT;
    end
    if (bad_exit || bad_stop_cs || bad_busy_stop) begin
      nxt_illegal = 1'b1; // [R17]
    end
  end

  // Decoded command and field registers
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cke_prev_ff <= 1'b1;
      good_cnt_ff <= 2'h0;
      clk_ok_cnt_ok_ff <= 1'b0;
      state_ff <= ST_NEED_INIT;
      illegal_ff <= 1'b0;
      cmd_valid_ff <= 1'b0;
      kind_ff <= CMD_NOP;
      ma_ff <= '0;
      op_ff <= '0;
      row_ff <= '0;
      bank_ff <= '0;
    end else begin
      cke_prev_ff <= cke_s2_ff;
      good_cnt_ff <= nxt_good_cnt;
      clk_ok_cnt_ok_ff <= ok_s2_ff;
      state_ff <= nxt_state;
      illegal_ff <= nxt_illegal;
      cmd_valid_ff <= (state_ff == ST_NORMAL) && !illegal_ff && !is_nop &&
        (is_mrw || is_mrr || is_act || is_dpd || is_pdn); // [R16]
      kind_ff <= is_nop ? CMD_NOP : is_mrw ? CMD_MRW :
        is_mrr ? CMD_MRR : is_act ? CMD_ACT : is_dpd ? CMD_DPD :
        is_pdn ? CMD_PDN : CMD_OTHR;
      if (is_mrw || is_mrr) begin
        ma_ff <= {caf_s2_ff[1:0], car_s2_ff[9:4]}; // [R18]
        op_ff <= caf_s2_ff[9:2];
      end
      if (is_act) begin
        row_ff <= {car_s2_ff[6:2], caf_s2_ff[7:0]}; // [R19]
        bank_ff <= car_s2_ff[9:7];
      end
    end
  end

  ready_wait_counter u_wait (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .start_in(wait_start),
    .clk_ok_in(ok_s2_ff),
    .done_out(wait_done)
  );

  // Outputs; busy work survives a no-operation untouched [R16]
  assign cmd_valid_out = cmd_valid_ff;
  assign cmd_kind_out = kind_ff;
  assign mr_addr_out = ma_ff;
  assign mr_data_out = op_ff;
  assign row_out = row_ff;
  assign bank_out = bank_ff;
  assign ready_out = (state_ff == ST_NORMAL) && !illegal_ff;
  assign need_init_out = (state_ff == ST_NEED_INIT) || illegal_ff;
  assign illegal_out = illegal_ff;
  assign op_hold_out = op_busy_in && clk_ok_cnt_ok_ff;
endmodule

/* verification/cmd_decode_props.sv */
/*
 Port checker for the command decoder.
 Assumes a bind to cmd_decode and the one clock domain.
*/
`timescale 1ns/10ps
module cmd_decode_props
  import cmd_decode_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic cke_in,
  input wire logic cs_b_in,
  input wire logic [CA_W-1:0] ca_rise_in,
  input wire logic [CA_W-1:0] ca_fall_in,
  input wire logic clk_ok_in,
  input wire logic init_done_in,
  input wire logic cmd_valid_out,
  input wire cmd_kind_e cmd_kind_out,
  input wire logic [MA_W-1:0] mr_addr_out,
  input wire logic [OP_W-1:0] mr_data_out,
  input wire logic [ROW_W-1:0] row_out,
  input wire logic [BANK_W-1:0] bank_out,
  input wire logic ready_out,
  input wire logic need_init_out,
  input wire logic illegal_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Pin cycle N shows up as a valid pulse three edges later
  a_nop_cs_idle: assert property (
    cs_b_in && cke_in && $past(cke_in) |-> ##3 !cmd_valid_out)
    else $error("deselect gave a command");
  a_nop_ca_idle: assert property (
    !cs_b_in && ca_rise_in[2:0] == 3'h7 && cke_in && $past(cke_in)
    |-> ##3 !cmd_valid_out) else $error("coded no-op gave a command");
  a_mr_fields: assert property (
    cmd_valid_out && cmd_kind_out == CMD_MRW |->
    $past(ca_rise_in[3:0], 3) == 4'h0 && !$past(cs_b_in, 3)
    && mr_data_out == $past(ca_fall_in[9:2], 3)
    && mr_addr_out == {$past(ca_fall_in[1:0], 3), $past(ca_rise_in[9:4], 3)})
    else $error("mode write fields wrong");
  a_act_fields: assert property (
    cmd_valid_out && cmd_kind_out == CMD_ACT |->
    $past(ca_rise_in[1:0], 3) == 2'h2 && bank_out == $past(ca_rise_in[9:7], 3)
    && row_out == {$past(ca_rise_in[6:2], 3), $past(ca_fall_in[7:0], 3)})
    else $error("activate fields wrong");
  a_cke_steady: assert property (
    cmd_valid_out && cmd_kind_out inside {CMD_MRW, CMD_MRR, CMD_ACT}
    |-> $past(cke_in, 3) && $past(cke_in, 4)) else $error("cke not steady");
  a_illegal_sticky: assert property (
    illegal_out && !init_done_in |=> illegal_out)
    else $error("illegal flag dropped");
  a_illegal_blocks: assert property (
    illegal_out && $past(illegal_out) |-> !ready_out && need_init_out)
    else $error("ready while illegal");
  a_stop_wait: assert property (
    $rose(clk_ok_in) |-> ##1 !ready_out [*2])
    else $error("ready too soon after stop");
  a_dpd_no_ready: assert property (
    cmd_valid_out && cmd_kind_out == CMD_DPD |-> !ready_out)
    else $error("ready after deep power-down entry");
endmodule

/* verification/host_ctrl_model.sv */
/*
 Behavioural memory controller driving clock qualifier and command pins.
 Assumes the bench calls send and stop between clock edges.
*/
`timescale 1ns/10ps
module host_ctrl_model
  import cmd_decode_pkg::*;
(
  input wire logic clock_in,
  output logic cke_out,
  output logic cs_b_out,
  output logic [CA_W-1:0] ca_rise_out,
  output logic [CA_W-1:0] ca_fall_out,
  output logic clk_ok_out
);
  // Enable moves only around deep power-down; commands see equal levels
  initial begin
    cke_out = 1'h1;
    cs_b_out = 1'h1;
    ca_rise_out = '0;
    ca_fall_out = '0;
    clk_ok_out = 1'h1;
  end
  // One cycle command, then a released bus shows flipped levels
  task automatic send(input logic cs_b, input logic [CA_W-1:0] r, f);
    @(posedge clock_in) #1;
    cs_b_out = cs_b;
    ca_rise_out = r;
    ca_fall_out = f;
    @(posedge clock_in) #1;
    cs_b_out = 1'h1;
    ca_rise_out = ~r;
    ca_fall_out = ~f;
  endtask
  // Parked clock with select high, unless told to misbehave
  task automatic stop(input int n, input logic bad_cs);
    @(posedge clock_in) #1;
    clk_ok_out = 1'h0;
    cs_b_out = !bad_cs;
    repeat (n) @(posedge clock_in);
    #1;
    clk_ok_out = 1'h1;
    cs_b_out = 1'h1;
  endtask
  // Deep power-down entry, stopped clock, then a qualified exit
  task automatic deep_pd(input int n);
    @(posedge clock_in) #1;
    cke_out = 1'h0;
    cs_b_out = 1'h0;
    ca_rise_out = 10'h003;
    ca_fall_out = '0;
    @(posedge clock_in) #1;
    cs_b_out = 1'h1; // Deselect while enable stays low
    @(posedge clock_in) #1;
    clk_ok_out = 1'h0; // Two cycles at the old rate first
    repeat (n) @(posedge clock_in);
    #1;
    clk_ok_out = 1'h1;
    repeat (CLK_QUAL_CYCLES) @(posedge clock_in);
    #1;
    cke_out = 1'h1; // Exit with select still high
  endtask
endmodule

/* verification/dram_clock_stop_cmd_decode_test.sv */
/*
 Self-checking bench for the command decoder.
 Assumes host_ctrl_model drives pins one time unit after each edge.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  num_errors++; $display("[ERR] %s exp %h seen %h", nm, ex, got); end end
module dram_clock_stop_cmd_decode_test;
  import cmd_decode_pkg::*;
  logic clock_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic init_done_in = 1'h0;
  logic op_busy_in = 1'h0;
  logic cke, cs_b, clk_ok, cmd_valid_out, ready_out;
  logic need_init_out, illegal_out, op_hold_out;
  logic [CA_W-1:0] ca_r, ca_f;
  cmd_kind_e cmd_kind_out;
  logic [MA_W-1:0] mr_addr_out;
  logic [OP_W-1:0] mr_data_out;
  logic [ROW_W-1:0] row_out;
  logic [BANK_W-1:0] bank_out;
  logic [18:0] exp_q[$];
  logic [18:0] e;
  logic [31:0] seed = 32'h0BA906F3;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int c;
  // Observed result packed like the notes in the queue
  // Power commands carry no fields, so they pack as zeros
  wire [18:0] seen = (cmd_kind_out == CMD_ACT) ?
    {cmd_kind_out, row_out, bank_out} :
    (cmd_kind_out inside {CMD_MRW, CMD_MRR}) ? {cmd_kind_out, mr_addr_out,
    (cmd_kind_out == CMD_MRR) ? 8'h00 : mr_data_out} :
    {cmd_kind_out, 16'h0000};
  always #4 clock_in = ~clock_in;
  host_ctrl_model host_u (.clock_in, .cke_out(cke), .cs_b_out(cs_b),
    .ca_rise_out(ca_r), .ca_fall_out(ca_f), .clk_ok_out(clk_ok));
  cmd_decode dut_u (.clock_in, .rst_b_in, .cke_in(cke), .cs_b_in(cs_b),
    .ca_rise_in(ca_r), .ca_fall_in(ca_f), .clk_ok_in(clk_ok),
    .init_done_in, .op_busy_in, .cmd_valid_out, .cmd_kind_out,
    .mr_addr_out, .mr_data_out, .row_out, .bank_out, .ready_out,
    .need_init_out, .illegal_out, .op_hold_out);
  task give_verdict;
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Bounded wait, so a stuck ready cannot hang the run
  task wait_ready;
    c = 0;
    while (ready_out !== 1'h1 && c < 40) begin
      @(posedge clock_in);
      #1;
      c++;
    end
    #1;
  endtask
  task init_and_wait;
    @(posedge clock_in) #1;
    init_done_in = 1'h1;
    @(posedge clock_in) #1;
    init_done_in = 1'h0;
    wait_ready();
  endtask
  // Random command of kind k; the note goes in before the pins move
  task rand_cmd(input int k);
    logic [CA_W-1:0] r, f;
    seed = lfsr(seed);
    r = seed[9:0];
    f = seed[19:10];
    if (k == 0) r[3:0] = 4'h0;
    if (k == 1) r[3:0] = 4'h8;
    if (k == 2) r[1:0] = 2'h2;
    if (k == 2) exp_q.push_back({CMD_ACT, r[6:2], f[7:0], r[9:7]});
    else exp_q.push_back({k ? CMD_MRR : CMD_MRW, f[1:0], r[9:4],
      k ? 8'h00 : f[9:2]});
    host_u.send(1'h0, r, f);
  endtask
  // Every valid pulse takes the oldest note; none left means spurious
  always @(negedge clock_in) begin
    if (rst_b_in && cmd_valid_out === 1'h1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 19'h7FFFF;
      `CHK("cmd", e, seen)
    end
  end
  // Hang guard, far above the roughly 120 cycles needed
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clock_in);
    #1;
    rst_b_in = 1'h1;
    `CHK("need_init", 1'h1, need_init_out)
    init_and_wait();
    for (int i = 0; i < 9; i++) begin
      rand_cmd(i % 3);
      host_u.send(1'h0, {seed[12:6], 3'h7}, seed[29:20]);
      host_u.send(1'h1, seed[9:0], seed[19:10]);
    end
    op_busy_in = 1'h1;
    host_u.send(1'h1, 10'h3FF, 10'h000);
    `CHK("hold", 1'h1, op_hold_out)
    op_busy_in = 1'h0;
    host_u.stop(5, 1'h0);
    `CHK("ready_stop", 1'h0, ready_out)
    wait_ready();
    `CHK("ready_wait", 1'h1, c >= READY_WAIT_CYCLES && c < 10)
    rand_cmd(0);
    host_u.stop(3, 1'h1);
    repeat (4) @(posedge clock_in);
    #1;
    `CHK("illegal", 1'h1, illegal_out)
    host_u.send(1'h0, 10'h000, 10'h3FF);
    `CHK("ready_ill", 1'h0, ready_out)
    init_and_wait();
    `CHK("ill_clear", 1'h0, illegal_out)
    exp_q.push_back({CMD_DPD, 16'h0000});
    host_u.deep_pd(4);
    repeat (4) @(posedge clock_in);
    #1;
    `CHK("dpd_exit", 1'h1, need_init_out)
    init_and_wait();
    rand_cmd(2);
    repeat (6) @(posedge clock_in);
    `CHK("drained", 0, exp_q.size())
    give_verdict();
  end
endmodule
bind cmd_decode cmd_decode_props chk_u (.clock_in, .rst_b_in, .cke_in,
  .cs_b_in, .ca_rise_in, .ca_fall_in, .clk_ok_in, .init_done_in,
  .cmd_valid_out, .cmd_kind_out, .mr_addr_out, .mr_data_out, .row_out,
  .bank_out, .ready_out, .need_init_out, .illegal_out);
